/* src/sbd_pkg.sv */
package sbd_pkg;
   // opcode fields of a subtract instruction word
   localparam logic [7:0] OPC_LIT_HI = 8'h08;       // literal_minus_working upper byte
   localparam logic [5:0] OPC_SWB = 6'h15;          // working_minus_register_borrow, bits 15:10
   localparam logic [5:0] OPC_SWF = 6'h17;          // register_minus_working, bits 15:10
   localparam int DEST_BIT = 9;
   localparam int ACC_BIT = 8;
   // access bank split: offsets below 8'h60 map to bank 0, 8'h60 and above to bank 15
   localparam logic [7:0] ACC_SPLIT = 8'h60;
   localparam logic [3:0] ACC_HI_BANK = 4'hF;
   localparam logic [3:0] BANK_SEL_RST = 4'h0;
   localparam logic [7:0] WORKING_RST = 8'h00;
   // status bit positions
   localparam int ST_C = 0;
   localparam int ST_DIG = 1;
   localparam int ST_Z = 2;
   localparam int ST_OVF = 3;
   localparam int ST_N = 4;
   localparam logic [4:0] STATUS_RST = 5'h00;
   // register-port offsets
   localparam logic [1:0] REG_WORKING = 2'h0;
   localparam logic [1:0] REG_STATUS = 2'h1;
   localparam logic [1:0] REG_BANK = 2'h2;
   localparam logic [1:0] REG_LAST = 2'h3;

   typedef enum logic [1:0] {OP_NONE, OP_LIT, OP_SWB, OP_SWF} sbd_op_t;
   typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} sbd_phase_t;
endpackage

/* src/sbd_alu_if.sv */
interface sbd_alu_if;
   logic [7:0] minuend;
   logic [7:0] subtrahend;
   logic borrow_in;
   logic [7:0] diff;
   logic [4:0] flags;
   modport core (output minuend, output subtrahend, output borrow_in, input diff, input flags);
   modport alu (input minuend, input subtrahend, input borrow_in, output diff, output flags);
endinterface

/* src/sbd_sub_alu.sv */
module sbd_sub_alu (
   sbd_alu_if.alu a
);
   logic [8:0] full;
   logic [4:0] half;
   // add the one's complement so bit 8 is the not-borrow carry
   always_comb begin
      full = {1'b0, a.minuend} + {1'b0, ~a.subtrahend} + {8'h00, ~a.borrow_in};
      half = {1'b0, a.minuend[3:0]} + {1'b0, ~a.subtrahend[3:0]} + {4'h0, ~a.borrow_in};
      a.diff = full[7:0];
      a.flags[sbd_pkg::ST_C] = full[8];
      a.flags[sbd_pkg::ST_DIG] = half[4];
      a.flags[sbd_pkg::ST_Z] = (full[7:0] == 8'h00);
      a.flags[sbd_pkg::ST_N] = full[7];
      a.flags[sbd_pkg::ST_OVF] = (a.minuend[7] != a.subtrahend[7]) && (full[7] != a.minuend[7]);
   end
endmodule // sbd_sub_alu

/* src/sbd_sub_datapath.sv */
// Function
// - literal_minus_working: literal minus working register, result to working register.
// - decode literal subtract from fixed upper byte, literal in lower byte.
// - every subtract updates N, overflow, C, digit carry and Z.
// - register_minus_working: addressed register minus working register.
// - destination bit 0 writes working register, 1 writes addressed register.
// - access bit 0 uses access bank, 1 uses bank_select_reg.
// - carry set when no borrow occurs.
// - carry cleared on borrow, wrapped result stored.
// - zero flag set when 8-bit result is zero.
// - negative flag follows result bit 7.
// - borrow variant uses inverted carry as extra borrow.
// - borrow variant: working minus register minus inverted carry, routed by destination.
module sbd_sub_datapath (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // instruction issue
   input wire logic [15:0] instr_word,
   input wire logic instr_valid,
   output logic instr_ready,
   output logic instr_done,
   output logic instr_illegal,
   // register file port
   output logic [11:0] rf_addr,
   output logic rf_rd,
   input wire logic [7:0] rf_rdata,
   output logic rf_wr,
   output logic [7:0] rf_wdata,
   // software register port
   input wire logic [1:0] sw_addr,
   input wire logic [7:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [7:0] sw_rdata,
   // visible state
   output logic [7:0] working_register,
   output logic [4:0] status_flags
);
   typedef struct packed {
      // sequencer
      sbd_pkg::sbd_phase_t phase;
      logic busy;
      // instruction held from decode to write-back
      sbd_pkg::sbd_op_t op;
      logic [7:0] lit;
      logic dest;
      logic [11:0] addr;
      // datapath values handed from phase to phase
      logic [7:0] operand;
      logic [7:0] result;
      logic [4:0] flags_new;
      // software-visible state
      logic [7:0] work;
      logic [4:0] status;
      logic [3:0] bank;
      logic [7:0] last;
      // registered outputs
      logic rd;
      logic wr;
      logic [7:0] wdata;
      logic done;
      logic illegal;
      logic [7:0] rdata;
   } sbd_state_t;

   sbd_state_t s_q, s_d;
   logic rst_m_q, rst_s_q;
   sbd_alu_if alu_bus ();
   // decoded view of the offered word, used only in Q1
   sbd_pkg::sbd_op_t dec_op;
   logic dec_dest;
   logic dec_acc;
   logic [11:0] dec_addr;
   // software port strobes split per register
   logic wr_working;
   logic wr_status;
   logic wr_bank;
   logic [7:0] rd_mux;

   // two-stage reset release so removal is synchronous
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rst_m_q <= 1'b0;
         rst_s_q <= 1'b0;
      end else begin
         rst_m_q <= 1'b1;
         rst_s_q <= rst_m_q;
      end
   end

   sbd_sub_alu u_alu (
      .a(alu_bus.alu)
   );

   // operand steering per instruction
   always_comb begin
      alu_bus.minuend = s_q.operand;
      alu_bus.subtrahend = s_q.work;
      alu_bus.borrow_in = 1'b0;
      case (s_q.op)
         sbd_pkg::OP_LIT: begin
            alu_bus.minuend = s_q.lit;
            alu_bus.subtrahend = s_q.work;
         end
         sbd_pkg::OP_SWF: begin
            alu_bus.minuend = s_q.operand;
            alu_bus.subtrahend = s_q.work;
         end
         sbd_pkg::OP_SWB: begin
            alu_bus.minuend = s_q.work;
            alu_bus.subtrahend = s_q.operand;
            alu_bus.borrow_in = ~s_q.status[sbd_pkg::ST_C];
         end
         default: begin
            alu_bus.borrow_in = 1'b0;
         end
      endcase
   end

   // instruction decode; only the three subtract opcodes are known, every other word is refused
   always_comb begin
      dec_dest = instr_word[sbd_pkg::DEST_BIT];
      dec_acc = instr_word[sbd_pkg::ACC_BIT];
      if (instr_word[15:8] == sbd_pkg::OPC_LIT_HI) begin
         dec_op = sbd_pkg::OP_LIT;
      end else if (instr_word[15:10] == sbd_pkg::OPC_SWB) begin
         dec_op = sbd_pkg::OP_SWB;
      end else if (instr_word[15:10] == sbd_pkg::OPC_SWF) begin
         dec_op = sbd_pkg::OP_SWF;
      end else begin
         dec_op = sbd_pkg::OP_NONE;
      end
   end

   // data address: the access bank puts low addresses in bank 0 and high ones in the top bank
   always_comb begin
      if (!dec_acc) begin
         if (instr_word[7:0] < sbd_pkg::ACC_SPLIT) begin
            dec_addr = {4'h0, instr_word[7:0]};
         end else begin
            dec_addr = {sbd_pkg::ACC_HI_BANK, instr_word[7:0]};
         end
      end else begin
         dec_addr = {s_q.bank, instr_word[7:0]};
      end
   end

   // software port decode; writes are dropped while an instruction runs so its cycle stays atomic
   always_comb begin
      wr_working = sw_wr && !s_q.busy && (sw_addr == sbd_pkg::REG_WORKING);
      wr_status = sw_wr && !s_q.busy && (sw_addr == sbd_pkg::REG_STATUS);
      wr_bank = sw_wr && !s_q.busy && (sw_addr == sbd_pkg::REG_BANK);
      case (sw_addr)
         sbd_pkg::REG_WORKING: rd_mux = s_q.work;
         sbd_pkg::REG_STATUS: rd_mux = {3'h0, s_q.status};
         sbd_pkg::REG_BANK: rd_mux = {4'h0, s_q.bank};
         default: rd_mux = s_q.last;                       // last result is read only
      endcase
   end

   // next-state: phase sequencer plus software port
   always_comb begin
      s_d = s_q;
      s_d.rd = 1'b0;
      s_d.wr = 1'b0;
      s_d.done = 1'b0;
      s_d.illegal = 1'b0;
      s_d.rdata = 8'h00;
      case (s_q.phase)
         sbd_pkg::PH_Q1: begin
            // decode: a word is taken only while idle
            if (instr_valid) begin
               s_d.lit = instr_word[7:0];
               s_d.dest = dec_dest;
               s_d.addr = dec_addr;
               s_d.op = dec_op;
               if (s_d.op == sbd_pkg::OP_NONE) begin
                  s_d.illegal = 1'b1;                      // unknown words are dropped in Q1
               end else begin
                  s_d.phase = sbd_pkg::PH_Q2;
                  s_d.busy = 1'b1;
                  s_d.rd = (s_d.op != sbd_pkg::OP_LIT);
               end
            end
         end
         sbd_pkg::PH_Q2: begin
            // read data is taken in the same cycle as the strobe
            if (s_q.op != sbd_pkg::OP_LIT) begin
               s_d.operand = rf_rdata;
            end
            s_d.phase = sbd_pkg::PH_Q3;
         end
         sbd_pkg::PH_Q3: begin
            // process: hold the difference and its flags for write-back
            s_d.result = alu_bus.diff;
            s_d.flags_new = alu_bus.flags;
            s_d.phase = sbd_pkg::PH_Q4;
         end
         sbd_pkg::PH_Q4: begin
            // write-back: status always, then the working register or the addressed register
            s_d.status = s_q.flags_new;
            s_d.last = s_q.result;
            if (s_q.op == sbd_pkg::OP_LIT || !s_q.dest) begin
               s_d.work = s_q.result;
            end else begin
               s_d.wr = 1'b1;
               s_d.wdata = s_q.result;
            end
            s_d.done = 1'b1;
            s_d.busy = 1'b0;
            s_d.phase = sbd_pkg::PH_Q1;
         end
         default: begin
            s_d.phase = sbd_pkg::PH_Q1;
         end
      endcase
      // software writes, already held off while busy
      if (wr_working) begin
         s_d.work = sw_wdata;
      end
      if (wr_status) begin
         s_d.status = sw_wdata[4:0];
      end
      if (wr_bank) begin
         s_d.bank = sw_wdata[3:0];
      end
      // read answer stands only in the cycle after the strobe
      if (sw_rd) begin
         s_d.rdata = rd_mux;
      end
   end

   // single state register
   always_ff @(posedge ref_clk or negedge rst_s_q) begin
      if (!rst_s_q) begin
         s_q <= '{
            phase: sbd_pkg::PH_Q1,
            busy: 1'b0,
            op: sbd_pkg::OP_NONE,
            lit: 8'h00,
            dest: 1'b0,
            addr: 12'h000,
            operand: 8'h00,
            result: 8'h00,
            flags_new: 5'h00,
            work: sbd_pkg::WORKING_RST,
            status: sbd_pkg::STATUS_RST,
            bank: sbd_pkg::BANK_SEL_RST,
            last: 8'h00,
            rd: 1'b0,
            wr: 1'b0,
            wdata: 8'h00,
            done: 1'b0,
            illegal: 1'b0,
            rdata: 8'h00
         };
      end else begin
         s_q <= s_d;
      end
   end

   // instruction handshake; ready follows the phase so a new word may be offered as done shows
   assign instr_ready = (s_q.phase == sbd_pkg::PH_Q1);
   assign instr_done = s_q.done;
   assign instr_illegal = s_q.illegal;

   // register file side, straight from flops
   assign rf_addr = s_q.addr;
   assign rf_rd = s_q.rd;
   assign rf_wr = s_q.wr;
   assign rf_wdata = s_q.wdata;

   // software port and visible state
   assign sw_rdata = s_q.rdata;
   assign working_register = s_q.work;
   assign status_flags = s_q.status;
endmodule // sbd_sub_datapath

/* testbench/sbd_sub_asserts.sv */
module sbd_sub_asserts (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // instruction side
   input wire logic [15:0] instr_word,
   input wire logic instr_valid,
   input wire logic instr_ready,
   input wire logic instr_done,
   input wire logic instr_illegal,
   // register file and state
   input wire logic [11:0] rf_addr,
   input wire logic rf_rd,
   input wire logic rf_wr,
   input wire logic [7:0] rf_wdata,
   input wire logic [7:0] working_register,
   input wire logic [4:0] status_flags
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);
   logic tk;
   logic lit;
   logic ok;
   logic [7:0] res;
   // decode seen at the port; res is the byte on whichever destination took it
   assign tk = instr_valid && instr_ready;
   assign lit = instr_word[15:8] == sbd_pkg::OPC_LIT_HI;
   assign ok = lit || instr_word[15:10] == sbd_pkg::OPC_SWB || instr_word[15:10] == sbd_pkg::OPC_SWF;
   assign res = rf_wr ? rf_wdata : working_register;
   done_latency_a: assert property (tk && ok |-> ##4 instr_done)
      else $error("done not four cycles after take");
   busy_phases_a: assert property (tk && ok |=> !instr_ready [*3] ##1 instr_ready)
      else $error("ready wrong during phases");
   reg_read_a: assert property (tk && ok && !lit |=> rf_rd ##1 !rf_rd)
      else $error("register read not one pulse");
   lit_noread_a: assert property (tk && lit |=> !rf_rd [*3] ##1 !rf_wr)
      else $error("literal op touched register file");
   access_bank_a: assert property (tk && ok && !lit && !instr_word[8] |=>
      rf_addr == ($past(instr_word[7:0]) < sbd_pkg::ACC_SPLIT ? {4'h0, $past(instr_word[7:0])}
      : {sbd_pkg::ACC_HI_BANK, $past(instr_word[7:0])}))
      else $error("access bank address wrong");
   zero_flag_a: assert property (instr_done |-> status_flags[sbd_pkg::ST_Z] == (res == 8'h00))
      else $error("zero flag disagrees with result");
   neg_flag_a: assert property (instr_done |-> status_flags[sbd_pkg::ST_N] == res[7])
      else $error("negative flag disagrees with result");
   write_with_done_a: assert property (rf_wr |-> instr_done)
      else $error("register write outside done cycle");
   bad_opcode_a: assert property (tk && !ok |=> instr_illegal && instr_ready)
      else $error("unknown word not refused");
endmodule // sbd_sub_asserts

/* testbench/tb_top.sv */
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 0;
   logic resetn = 0;
   logic [15:0] instr_word = 0;
   logic instr_valid = 0;
   logic [7:0] rf_rdata = 0;
   logic [1:0] sw_addr = 0;
   logic [7:0] sw_wdata = 0;
   logic sw_wr = 0;
   logic sw_rd = 0;
   logic instr_ready, instr_done, instr_illegal, rf_rd, rf_wr;
   logic [11:0] rf_addr;
   logic [7:0] rf_wdata, sw_rdata, working_register;
   logic [4:0] status_flags;
   int n_errors = 0;
   int tests_run = 0;
   int n_ill = 0;
   integer seed = 32'hBEE90560;
   logic [26:0] iq[$];
   logic [7:0] swq[$];
   logic [26:0] e;
   logic rd_q = 0;
   sbd_sub_datapath dut (.ref_clk(ref_clk), .resetn(resetn), .instr_word(instr_word), .instr_valid(instr_valid),
      .instr_ready(instr_ready), .instr_done(instr_done), .instr_illegal(instr_illegal), .rf_addr(rf_addr),
      .rf_rd(rf_rd), .rf_rdata(rf_rdata), .rf_wr(rf_wr), .rf_wdata(rf_wdata), .sw_addr(sw_addr),
      .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
      .working_register(working_register), .status_flags(status_flags));
   always #50 ref_clk = ~ref_clk;
   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // reference subtract: negative, overflow, zero, digit carry, carry (bits 4..0) above the result byte
   function automatic logic [12:0] sub_ref(logic [7:0] m, logic [7:0] s, logic b);
      logic [8:0] r;
      logic [4:0] q;
      r = {1'b0, m} - {1'b0, s} - b;
      q[0] = !r[8];
      q[1] = {1'b0, m[3:0]} >= {1'b0, s[3:0]} + b;
      q[2] = r[7:0] == 8'h00;
      q[3] = (m[7] != s[7]) && (r[7] != m[7]);
      q[4] = r[7];
      return {q, r[7:0]};
   endfunction
   // a read strobe queues its expected byte; strobes always have a gap here
   task automatic sw(logic w, logic [1:0] a, logic [7:0] d);
      @(posedge ref_clk);
      sw_wr <= w;
      sw_rd <= !w;
      sw_addr <= a;
      sw_wdata <= d;
      if (!w) swq.push_back(d);
      @(posedge ref_clk);
      sw_wr <= 0;
      sw_rd <= 0;
   endtask
   // read data held valid for the whole instruction, inverted once released
   task automatic run(logic [15:0] w, logic [7:0] fd);
      @(posedge ref_clk);
      instr_word <= w;
      instr_valid <= 1;
      rf_rdata <= fd;
      @(posedge ref_clk);
      instr_valid <= 0;
      repeat (4) @(posedge ref_clk);
      rf_rdata <= ~fd;
   endtask
   // result monitor: oldest note against each done pulse and each read answer
   always @(posedge ref_clk) begin
      if (instr_illegal === 1'b1) n_ill++;
      if (rd_q) chk("sw_rdata", sw_rdata, swq.pop_front());
      rd_q <= sw_rd;
      if (instr_done === 1'b1) begin
         e = iq.pop_front();
         chk("rf_wr", rf_wr, e[25]);
         chk("result", e[25] ? rf_wdata : working_register, e[7:0]);
         chk("status", status_flags, e[12:8]);
         if (!e[26]) chk("rf_addr", rf_addr, e[24:13]);
      end
   end
   initial begin : main
      logic [7:0] w, fd, wm;
      logic [4:0] st;
      logic [3:0] bk;
      logic d, a, lit;
      logic [12:0] r;
      logic [15:0] word;
      repeat (16) @(posedge ref_clk);
      resetn <= 1;
      repeat (3) @(posedge ref_clk);
      sw(0, sbd_pkg::REG_STATUS, 8'h00);
      for (int i = 0; i < 60; i++) begin
         w = $random(seed);
         fd = $random(seed);
         st = $random(seed);
         bk = $random(seed);
         {d, a} = $random(seed);
         if (i % 4 == 0) fd = w; // zero results and borrow edge
         lit = i % 3 == 0;
         sw(1, sbd_pkg::REG_WORKING, w);
         sw(1, sbd_pkg::REG_STATUS, {3'h0, st});
         sw(1, sbd_pkg::REG_BANK, {4'h0, bk});
         if (lit) word = {sbd_pkg::OPC_LIT_HI, fd};
         else word = {i % 3 == 1 ? sbd_pkg::OPC_SWF : sbd_pkg::OPC_SWB, d, a, fd};
         if (i % 3 == 2) r = sub_ref(w, fd, !st[sbd_pkg::ST_C]);
         else r = sub_ref(fd, w, 1'b0);
         iq.push_back({lit, d && !lit, a ? {bk, fd} : fd < sbd_pkg::ACC_SPLIT ? {4'h0, fd}
            : {sbd_pkg::ACC_HI_BANK, fd}, r});
         run(word, fd);
         wm = (lit || !d) ? r[7:0] : w;
      end
      sw(0, sbd_pkg::REG_WORKING, wm);
      sw(1, sbd_pkg::REG_LAST, ~r[7:0]);
      sw(0, sbd_pkg::REG_LAST, r[7:0]);
      $display("test subtract ops done");
      run(16'hFFFF, 8'h00);
      chk("illegal", n_ill, 1);
      $display("test refusal done");
      end_sim();
   end
   // hang guard, far beyond the roughly 750 cycles the tests take
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      end_sim();
   end
endmodule // tb_top
bind sbd_sub_datapath sbd_sub_asserts u_chk (.ref_clk(ref_clk), .resetn(resetn), .instr_word(instr_word),
   .instr_valid(instr_valid), .instr_ready(instr_ready), .instr_done(instr_done), .instr_illegal(instr_illegal),
   .rf_addr(rf_addr), .rf_rd(rf_rd), .rf_wr(rf_wr), .rf_wdata(rf_wdata), .working_register(working_register),
   .status_flags(status_flags));
